// ===== pia_consts.vh
// Constants for the PHY identifier and ability register bank
`ifndef PIA_CONSTS_VH
`define PIA_CONSTS_VH

// Register offsets (16-bit registers, word index)
`define PIA_ADDR_W          5
`define PIA_OFS_STATUS      5'h01
`define PIA_OFS_ID_HIGH     5'h02
`define PIA_OFS_ID_LOW      5'h03
`define PIA_OFS_LOCAL_ADV   5'h04
`define PIA_OFS_PARTNER     5'h05

// Identifier field positions
`define PIA_ID_OUI_HI       15:10
`define PIA_ID_MODEL        9:4
`define PIA_ID_REV          3:0
`define PIA_OUI_HIGH_BITS   21:6
`define PIA_OUI_LOW_BITS    5:0

// Local advertisement fields
`define PIA_ADV_NEXT_PAGE   15
`define PIA_ADV_RFAULT      13
`define PIA_ADV_SPARE       12
`define PIA_ADV_ASYM        11
`define PIA_ADV_PAUSE       10
`define PIA_ADV_T4          9
`define PIA_ADV_SPEEDS      8:5
`define PIA_ADV_SELECTOR    4:0
`define PIA_ADV_WRITE_MASK  16'hbde0
`define PIA_SELECTOR_RESET  5'h01
`define PIA_SPEEDS_DEFAULT  4'hf

// Partner register
`define PIA_PARTNER_RESET   16'h0000
`define PIA_PARTNER_MASK    16'hefff

// Status register negotiation complete bit
`define PIA_STATUS_DONE     5
`define PIA_ZERO16          16'h0000

`endif

// ===== pia_regs.v
// PHY identifier, local advertisement and partner ability register bank
//
// Notes on behaviour
// - Two read-only registers form a 32-bit identifier: OUI, model, revision.
// - High identifier register returns OUI bits 3 to 18, MSB first.
// - Low identifier bits 15 to 10 return OUI bits 19 to 24.
// - Low identifier bits 9 to 4 return the six-bit model number.
// - Low identifier bits 3 to 0 return the four-bit revision number.
// - Local advertisement register content is sent to the partner during negotiation.
// - Advertisement bit 15 requests extra next pages; resets to zero.
// - Advertisement bit 13 advertises remote fault detection; resets to zero.
// - Bits 11 and 10 advertise asymmetric pause and pause; reset zero.
// - Bit 9, the unsupported T4 ability, is never advertised.
// - Bits 8 to 5 advertise speeds; defaults from straps, all ones unstrapped.
// - Bits 4 to 0 hold the technology selector, resetting to 00001.
// - Partner register captures received partner abilities; resets to zero.
// - With next pages, partner register may change after negotiation completes.
// - Partner bits 15, 14, 13, 11, 10: next page, ack, fault, pauses.
// - Partner bits 9 to 5 speeds, bits 4 to 0 selector.
// - Negotiation complete status bit is set only once negotiation finishes.
//
// Added by the designer: the plain strobed port.
`include "pia_consts.vh"
`default_nettype none

module pia_regs #(
    parameter [21:0] OUI_VALUE   = 22'h2a5a5a, // Arbitrary value
    parameter [5:0]  MODEL_VALUE = 6'h15,      // Arbitrary value
    parameter [3:0]  REV_VALUE   = 4'h1,       // Arbitrary value
    parameter        NEXT_PAGE_SUPPORT = 1
) (
    // Clock and reset
    input  wire                     SYS_CLK,
    input  wire                     SYS_RST,
    // Strap levels for speed defaults, caught after reset release
    input  wire [3:0]               SPEED_STRAP,
    input  wire                     SPEED_STRAP_VALID,
    // Register port
    input  wire [`PIA_ADDR_W-1:0]   ADDR,
    input  wire [15:0]              WDATA,
    input  wire                     WR,
    input  wire                     RD,
    output reg  [15:0]              RDATA,
    // Negotiation engine side
    output wire [15:0]              ADV_WORD,
    input  wire                     PARTNER_VALID,
    input  wire [15:0]              PARTNER_WORD,
    input  wire                     NEG_DONE,
    output reg                      NEG_COMPLETE
);

    ////////////////////////////////////////////////////////////////////
    // Storage

    reg  [15:0] local_adv;
    reg  [15:0] partner;
    reg         strap_taken;
    reg  [15:0] next_rdata;

    wire [15:0] id_high;
    wire [15:0] id_low;
    wire [15:0] status_word;

    ////////////////////////////////////////////////////////////////////
    // Identifier words

    // OUI bits 3..18 go out on the high register
    assign id_high = OUI_VALUE[`PIA_OUI_HIGH_BITS];
    // OUI tail, model and revision on the low register
    assign id_low = {OUI_VALUE[`PIA_OUI_LOW_BITS],
                     MODEL_VALUE,
                     REV_VALUE};

    // Only the completion bit is held here; the rest reads zero
    assign status_word = {{(15-`PIA_STATUS_DONE){1'b0}}, NEG_COMPLETE,
                          {`PIA_STATUS_DONE{1'b0}}};

    ////////////////////////////////////////////////////////////////////
    // Local advertisement register

    // ADV_WORD is local_adv as stored; T4 stays low because writes to it are ignored
    assign ADV_WORD = local_adv;

    // Writable fields; T4 and reserved bit 14 ignore writes
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            local_adv                     <= `PIA_ZERO16;
            local_adv[`PIA_ADV_SPEEDS]    <= `PIA_SPEEDS_DEFAULT;
            local_adv[`PIA_ADV_SELECTOR]  <= `PIA_SELECTOR_RESET;
            strap_taken                   <= 1'b0;
        end else if (WR && ADDR == `PIA_OFS_LOCAL_ADV) begin
            local_adv   <= WDATA & `PIA_ADV_WRITE_MASK | {11'h000, WDATA[`PIA_ADV_SELECTOR]};
            strap_taken <= 1'b1;
        end else if (!strap_taken && SPEED_STRAP_VALID) begin
            // Straps override the unstrapped speed default once
            local_adv[`PIA_ADV_SPEEDS] <= SPEED_STRAP;
            strap_taken                <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Partner abilities and completion flag

    // Capture partner word; after completion only with next pages
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            partner      <= `PIA_PARTNER_RESET;
            NEG_COMPLETE <= 1'b0;
        end else begin
            if (PARTNER_VALID && (!NEG_COMPLETE || NEXT_PAGE_SUPPORT != 0)) begin
                partner <= PARTNER_WORD & `PIA_PARTNER_MASK;
            end
            NEG_COMPLETE <= NEG_DONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path

    // Address decode; unmapped offsets read zero
    always @* begin
        if (ADDR == `PIA_OFS_ID_HIGH) begin
            next_rdata = id_high;
        end else if (ADDR == `PIA_OFS_ID_LOW) begin
            next_rdata = id_low;
        end else if (ADDR == `PIA_OFS_LOCAL_ADV) begin
            next_rdata = local_adv;
        end else if (ADDR == `PIA_OFS_PARTNER) begin
            next_rdata = partner;
        end else if (ADDR == `PIA_OFS_STATUS) begin
            next_rdata = status_word;
        end else begin
            next_rdata = `PIA_ZERO16;
        end
    end

    // Read data stands one cycle after the strobe only
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            RDATA <= `PIA_ZERO16;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= `PIA_ZERO16;
        end
    end

endmodule // pia_regs

`default_nettype wire

// ===== pia_assertions.sv
// Port checker for the identifier and ability register bank
`default_nettype none
module pia_assertions (
    input wire logic        SYS_CLK, SYS_RST, WR, RD, SPEED_STRAP_VALID,
    input wire logic        PARTNER_VALID, NEG_DONE, NEG_COMPLETE,
    input wire logic [4:0]  ADDR,
    input wire logic [15:0] WDATA, RDATA, ADV_WORD, PARTNER_WORD
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    sequence adv_wr; WR && ADDR == 5'h04; endsequence
    sequence part_rd; PARTNER_VALID && !NEG_COMPLETE ##1 RD && ADDR == 5'h05; endsequence
    AST_IDLE: assert property (!RD |=> RDATA == 16'h0) else $error("idle rdata");
    AST_RESV: assert property (!ADV_WORD[14] && !ADV_WORD[9]) else $error("adv resv");
    AST_WR: assert property (adv_wr |=> ADV_WORD == ($past(WDATA) & 16'hbdff))
        else $error("adv write");
    AST_HOLD: assert property (!(WR && ADDR == 5'h04) && !SPEED_STRAP_VALID |=> $stable(ADV_WORD))
        else $error("adv hold");
    AST_ARD: assert property (RD && ADDR == 5'h04 |=> RDATA == $past(ADV_WORD))
        else $error("adv read");
    AST_PRD: assert property (part_rd |=> RDATA == ($past(PARTNER_WORD, 2) & 16'hefff))
        else $error("partner read");
    AST_DONE: assert property (NEG_DONE |=> NEG_COMPLETE) else $error("done rise");
    AST_BUSY: assert property (!NEG_DONE |=> !NEG_COMPLETE) else $error("done early");
    AST_STS: assert property (RD && ADDR == 5'h01 |=> RDATA == {10'h0, $past(NEG_COMPLETE), 5'h0})
        else $error("status read");
endmodule // pia_assertions
bind pia_regs pia_assertions CHK (.*);
`default_nettype wire

// ===== pia_partner.sv
// Link partner model: sends one page, then reports negotiation state
`default_nettype none
module pia_partner (
    input  wire logic        SYS_CLK,
    output var  logic        PARTNER_VALID = 1'h0,
    output var  logic [15:0] PARTNER_WORD = 16'h0,
    output var  logic        NEG_DONE = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Page after a wait; word lines carry the inverted word once the pulse ends
    task automatic send(input logic [15:0] w, input int gap, input logic fin);
        repeat (gap) @(posedge SYS_CLK);
        PARTNER_VALID <= 1'h1;
        PARTNER_WORD  <= w;
        @(posedge SYS_CLK);
        PARTNER_VALID <= 1'h0;
        PARTNER_WORD  <= ~w;
        NEG_DONE      <= fin;
    endtask
endmodule // pia_partner
`default_nettype wire

// ===== pia_regs_tb.sv
// Bench for the identifier and ability register bank
`default_nettype none
module pia_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [21:0] OUI = 22'h1c3a5e; // Arbitrary value
    localparam logic [5:0]  MDL = 6'h2b;      // Arbitrary value
    localparam logic [3:0]  REV = 4'h6;       // Arbitrary value
    logic SYS_CLK = 0, SYS_RST = 1, WR = 0, RD = 0, SPEED_STRAP_VALID = 0;
    logic PARTNER_VALID, NEG_DONE, NEG_COMPLETE;
    logic [4:0]  ADDR = 0;
    logic [3:0]  SPEED_STRAP = 4'ha;
    logic [15:0] WDATA = 0, RDATA, ADV_WORD, PARTNER_WORD;
    int fail_count = 0, n_checks = 0;
    pia_regs #(.OUI_VALUE(OUI), .MODEL_VALUE(MDL), .REV_VALUE(REV)) DUT (.*);
    pia_partner P (.*);
    always #5 SYS_CLK = ~SYS_CLK;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rst(input logic v);
        SYS_RST <= 1'h1;
        SPEED_STRAP_VALID <= v;
        repeat (6) @(posedge SYS_CLK);
        SYS_RST <= 1'h0;
        @(posedge SYS_CLK);
        SPEED_STRAP_VALID <= 1'h0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'h1;
        @(posedge SYS_CLK);
        WR <= 1'h0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        ADDR <= a;
        RD <= 1'h1;
        @(posedge SYS_CLK);
        RD <= 1'h0;
        #1 chk(RDATA, e);
        @(posedge SYS_CLK);
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Reset values, identifier, write masks, straps, partner capture
    initial begin
        rst(1'h0);
        rd(5'h04, 16'h01e1);
        rd(5'h05, 16'h0000);
        rd(5'h02, OUI[21:6]);
        rd(5'h03, {OUI[5:0], MDL, REV});
        rd(5'h01, 16'h0000);
        rd(5'h07, 16'h0000);
        wr(5'h04, 16'hffff);
        rd(5'h04, 16'hbdff);
        wr(5'h05, 16'hffff);
        rd(5'h05, 16'h0000);
        wr(5'h04, 16'h5a5a);
        rd(5'h04, 16'h185a);
        chk(ADV_WORD, 16'h185a);
        rst(1'h1);
        rd(5'h04, 16'h0141);
        P.send(16'hffff, 0, 1'h0);
        rd(5'h05, 16'hefff);
        P.send(16'h1234, 3, 1'h1);
        rd(5'h05, 16'h0234);
        rd(5'h01, 16'h0020);
        P.send(16'h4321, 0, 1'h1);
        rd(5'h05, 16'h4321);
        test_done();
    end
    // Watchdog against a hang
    initial begin
        #20us;
        fail_count++;
        test_done();
    end
endmodule // pia_regs_tb
`default_nettype wire
